// ===== rtl/dcg_clock_gen.sv
// Design decisions made here: register access over AHB-Lite and the register offsets.
`default_nettype none
module dcg_clock_gen #(
  parameter longint LOCK_CYCLES = dcg_pkg::LOCK_CYCLES
) (
  // Clock and reset
  input wire logic REF_CLK_IN,
  input wire logic RST_N_IN,
  // Mode pins
  input wire logic CLOCK_MODE_PIN_A_IN,
  input wire logic CLOCK_MODE_PIN_B_IN,
  input wire logic CLOCK_MODE_PIN_C_IN,
  // AHB-Lite slave
  input wire logic HSEL_IN,
  input wire logic [31:0] HADDR_IN,
  input wire logic [1:0] HTRANS_IN,
  input wire logic HWRITE_IN,
  input wire logic [2:0] HSIZE_IN,
  input wire logic [31:0] HWDATA_IN,
  input wire logic HREADY_IN,
  output logic [31:0] HRDATA_OUT,
  output logic HREADYOUT_OUT,
  output logic HRESP_OUT,
  // Clock outputs
  output logic MACHINE_CLK_EN_OUT,
  output logic MACHINE_CLOCK_OUTPUT_OUT,
  output logic CRYSTAL_OSC_EN_OUT,
  output logic PLL_LOCKED_OUT,
  output logic [3:0] PLL_MULT_OUT,
  output logic [1:0] PLL_FRAC_OUT
);
  // Mode, pin latch and bus write state
  dcg_pkg::dcg_mode_type mode_q, mode_d;
  logic [1:0] out_sel_q, out_sel_d;
  logic [2:0] pins_q, pins_d;
  logic latch_pend_q, latch_pend_d;
  logic osc_en_q, osc_en_d;
  logic wr_pend_q, wr_pend_d;
  logic [7:0] wr_addr_q, wr_addr_d;
  // Address phase taken this cycle
  logic addr_ok;
  // Pulse that restarts the lock timer
  logic restart;

  // Read data
  logic [31:0] rdata_q, rdata_d;

  // Lock timer
  dcg_pkg::dcg_lock_state_type lock_st_q, lock_st_d;
  logic [63:0] lock_cnt_q, lock_cnt_d;

  // Machine clock enable
  logic [1:0] mdiv_q, mdiv_d;
  logic mclk_en_q, mclk_en_d;
  logic [5:0] phase_q, phase_d;
  logic [7:0] frac_acc_q, frac_acc_d;

  // Clock output divider
  logic [1:0] odiv_q, odiv_d;
  logic machine_clock_output_q, machine_clock_output_d;

  // Two-bit wrapping step shared by both dividers
  function automatic logic [1:0] step2(input logic [1:0] v);
    return v + 2'h1;
  endfunction

  function automatic logic is_locked(input dcg_pkg::dcg_lock_state_type s);
    return s == dcg_pkg::DCG_LOCK_DONE;
  endfunction

  // Reset-time mode from the latched pin pattern
  function automatic dcg_pkg::dcg_mode_type mode_from_pins(input logic [2:0] p);
    dcg_pkg::dcg_mode_type m;
    m = '0;
    m.mult = dcg_pkg::MULT_RESET;
    unique case (p)
      dcg_pkg::PINS_DIV2_LO, dcg_pkg::PINS_DIV2_HI: begin
        m.pll_on = 1'b0;
        m.div4 = 1'b0;
      end
      dcg_pkg::PINS_DIV4: begin
        m.pll_on = 1'b0;
        m.div4 = 1'b1;
      end
      // Unlisted patterns run the loop at x1
      default: begin
        m.pll_on = 1'b1;
      end
    endcase
    return m;
  endfunction

  // Register read mux; unmapped offsets read zero
  function automatic logic [31:0] read_reg(input logic [7:0] a, input dcg_pkg::dcg_mode_type m,
                                           input logic [1:0] dv, input logic lk, input logic osc,
                                           input logic [2:0] p);
    logic [31:0] r;
    r = '0;
    unique case (a)
      dcg_pkg::CLK_MODE_ADDR: r[7:0] = m;
      dcg_pkg::BANK_SW_ADDR: r[dcg_pkg::OUT_DIV_LSB +: dcg_pkg::OUT_DIV_W] = dv;
      dcg_pkg::STATUS_ADDR: begin
        r[dcg_pkg::LOCK_BIT] = lk;
        r[dcg_pkg::OSC_BIT] = osc;
        r[dcg_pkg::PINS_LSB +: $bits(p)] = p;
      end
      default: r = '0;
    endcase
    return r;
  endfunction

  // Bus decode and register writes
  always_comb begin
    addr_ok = HSEL_IN && HREADY_IN && HTRANS_IN[1];
    mode_d = mode_q;
    out_sel_d = out_sel_q;
    pins_d = pins_q;
    latch_pend_d = 1'b0;
    osc_en_d = osc_en_q;
    restart = 1'b0;
    wr_pend_d = addr_ok && HWRITE_IN;
    wr_addr_d = addr_ok ? HADDR_IN[7:0] : wr_addr_q;
    // Pin latch outranks a bus write in the first cycle after reset
    if (latch_pend_q) begin
      pins_d = {CLOCK_MODE_PIN_A_IN, CLOCK_MODE_PIN_B_IN, CLOCK_MODE_PIN_C_IN};
      mode_d = mode_from_pins(pins_d);
      osc_en_d = (pins_d == dcg_pkg::PINS_OSC_DIV2);
      restart = mode_d.pll_on;
    end else if (wr_pend_q) begin
      if (wr_addr_q == dcg_pkg::CLK_MODE_ADDR) begin
        mode_d = dcg_pkg::dcg_mode_type'(HWDATA_IN[7:0]);
        // A zero multiplier with the loop on is forced to one
        if (mode_d.pll_on && mode_d.mult == '0) mode_d.mult = dcg_pkg::MULT_RESET;
        restart = mode_d.pll_on;
      end else if (wr_addr_q == dcg_pkg::BANK_SW_ADDR) begin
        out_sel_d = HWDATA_IN[dcg_pkg::OUT_DIV_LSB +: dcg_pkg::OUT_DIV_W];
      end
    end
  end

  // Read data captured in the address phase
  always_comb begin
    rdata_d = rdata_q;
    if (addr_ok && !HWRITE_IN) begin
      rdata_d = read_reg(HADDR_IN[7:0], mode_q, out_sel_q, is_locked(lock_st_q), osc_en_q, pins_q);
    end
  end

  // Lock timer
  always_comb begin
    lock_st_d = lock_st_q;
    lock_cnt_d = lock_cnt_q;
    if (restart) begin
      lock_st_d = dcg_pkg::DCG_LOCK_WAIT;
      lock_cnt_d = '0;
    end else if (!mode_q.pll_on) begin
      // Leaving PLL mode drops lock at once
      lock_st_d = dcg_pkg::DCG_LOCK_IDLE;
    end else begin
      unique case (lock_st_q)
        dcg_pkg::DCG_LOCK_IDLE: lock_st_d = dcg_pkg::DCG_LOCK_IDLE;
        dcg_pkg::DCG_LOCK_WAIT: begin
          lock_cnt_d = lock_cnt_q + 64'h1;
          if (lock_cnt_q >= 64'(LOCK_CYCLES) - 64'h1) lock_st_d = dcg_pkg::DCG_LOCK_DONE;
        end
        // Timer holds at terminal count until a clock mode write with pll_on set, or until pll_on is cleared
        dcg_pkg::DCG_LOCK_DONE: lock_st_d = dcg_pkg::DCG_LOCK_DONE;
        default: lock_st_d = dcg_pkg::DCG_LOCK_IDLE;
      endcase
    end
  end

  // Machine clock enable: divide or multiply-path rate
  always_comb begin
    logic [7:0] step;
    step = {mode_q.mult, mode_q.frac, 2'h0};
    mdiv_d = mdiv_q;
    mclk_en_d = 1'b0;
    phase_d = phase_q;
    frac_acc_d = frac_acc_q;
    if (mode_q.pll_on) begin
      // Reference rate scaled by N/16 as a full-rate fraction stand-in
      {mclk_en_d, frac_acc_d} = {1'b0, frac_acc_q} + {1'b0, step};
    end else begin
      // Bypass: one pulse per two or four reference edges
      mdiv_d = step2(mdiv_q);
      if (mode_q.div4) begin
        mclk_en_d = (mdiv_q == 2'h3);
      end else begin
        mclk_en_d = mdiv_q[0];
      end
    end
  end

  // Clock output divider
  always_comb begin
    odiv_d = odiv_q;
    machine_clock_output_d = machine_clock_output_q;
    if (mclk_en_q) begin
      odiv_d = step2(odiv_q);
      unique case (out_sel_q)
        dcg_pkg::OUT_DIV_NONE: machine_clock_output_d = ~machine_clock_output_q;
        dcg_pkg::OUT_DIV_BY2: begin
          if (odiv_q[0]) machine_clock_output_d = ~machine_clock_output_q;
        end
        default: begin
          if (odiv_q == 2'h3) machine_clock_output_d = ~machine_clock_output_q;
        end
      endcase
    end
  end

  // Mode and bus state, held while the reference stops
  always_ff @(posedge REF_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      mode_q <= '0;
      out_sel_q <= dcg_pkg::OUT_DIV_RESET;
      pins_q <= '0;
      latch_pend_q <= 1'b1;
      osc_en_q <= 1'b0;
      wr_pend_q <= 1'b0;
      wr_addr_q <= '0;
    end else begin
      mode_q <= mode_d;
      out_sel_q <= out_sel_d;
      pins_q <= pins_d;
      latch_pend_q <= latch_pend_d;
      osc_en_q <= osc_en_d;
      wr_pend_q <= wr_pend_d;
      wr_addr_q <= wr_addr_d;
    end
  end

  // Read data register
  always_ff @(posedge REF_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      rdata_q <= '0;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  // Lock timer state
  always_ff @(posedge REF_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      lock_st_q <= dcg_pkg::DCG_LOCK_IDLE;
      lock_cnt_q <= '0;
    end else begin
      lock_st_q <= lock_st_d;
      lock_cnt_q <= lock_cnt_d;
    end
  end

  // Machine clock enable state
  always_ff @(posedge REF_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      mdiv_q <= '0;
      mclk_en_q <= 1'b0;
      phase_q <= '0;
      frac_acc_q <= '0;
    end else begin
      mdiv_q <= mdiv_d;
      mclk_en_q <= mclk_en_d;
      phase_q <= phase_d;
      frac_acc_q <= frac_acc_d;
    end
  end

  // Clock output divider state
  always_ff @(posedge REF_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      odiv_q <= '0;
      machine_clock_output_q <= 1'b0;
    end else begin
      odiv_q <= odiv_d;
      machine_clock_output_q <= machine_clock_output_d;
    end
  end

  // Bus handshake and clock outputs
  assign HRDATA_OUT = rdata_q;
  assign HREADYOUT_OUT = 1'b1;
  assign HRESP_OUT = 1'b0;
  assign MACHINE_CLK_EN_OUT = mclk_en_q;
  assign MACHINE_CLOCK_OUTPUT_OUT = machine_clock_output_q;
  assign CRYSTAL_OSC_EN_OUT = osc_en_q;
  assign PLL_LOCKED_OUT = is_locked(lock_st_q);
  assign PLL_MULT_OUT = mode_q.mult;
  assign PLL_FRAC_OUT = mode_q.frac;
  // Bus fields this slave does not decode, and the unused phase_q
  logic unused_ok;
  assign unused_ok = addr_ok ^ HSIZE_IN[0] ^ HTRANS_IN[0] ^ (|HADDR_IN[31:8]) ^ (|phase_q);
endmodule
`default_nettype wire

// ===== rtl/dcg_pkg.sv
`default_nettype none
package dcg_pkg;
  // Register byte addresses
  localparam logic [7:0] CLK_MODE_ADDR = 8'h00;
  localparam logic [7:0] BANK_SW_ADDR = 8'h04;
  localparam logic [7:0] STATUS_ADDR = 8'h08;
  // Clock mode register fields
  localparam int MULT_LSB = 4;
  localparam int MULT_W = 4;
  localparam int FRAC_LSB = 2;
  localparam int FRAC_W = 2;
  localparam int PLL_ON_BIT = 1;
  localparam int DIV4_BIT = 0;
  // Bank switch register field: clock output divide select
  localparam int OUT_DIV_LSB = 0;
  localparam int OUT_DIV_W = 2;
  localparam logic [1:0] OUT_DIV_NONE = 2'h0;
  localparam logic [1:0] OUT_DIV_BY2 = 2'h1;
  localparam logic [1:0] OUT_DIV_BY4 = 2'h2;
  localparam logic [1:0] OUT_DIV_RESET = OUT_DIV_BY4;
  // Status bits
  localparam int LOCK_BIT = 0;
  localparam int OSC_BIT = 1;
  localparam int PINS_LSB = 4;
  // Mode pin patterns (a,b,c)
  localparam logic [2:0] PINS_DIV2_LO = 3'h0;
  localparam logic [2:0] PINS_DIV4 = 3'h5;
  localparam logic [2:0] PINS_DIV2_HI = 3'h7;
  localparam logic [2:0] PINS_OSC_DIV2 = 3'h7;
  localparam logic [3:0] MULT_RESET = 4'h1;
  // Timing
  localparam int CLK_MHZ = 125;
  localparam int LOCK_TIME_MS = 30;
  localparam longint LOCK_CYCLES = longint'(LOCK_TIME_MS) * CLK_MHZ * 1000;
  // AHB
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] HTRANS_SEQ = 2'h3;

  typedef struct packed {
    logic [3:0] mult;
    logic [1:0] frac;
    logic pll_on;
    logic div4;
  } dcg_mode_type;

  typedef enum logic [1:0] {
    DCG_LOCK_IDLE,
    DCG_LOCK_WAIT,
    DCG_LOCK_DONE
  } dcg_lock_state_type;
endpackage
`default_nettype wire

// ===== sim/dcg_ref_src.sv
`default_nettype none
module dcg_ref_src #(parameter int HALF_NS = 4) (
  // Control
  input wire logic STOP_IN,
  // Reference clock
  output var logic REF_CLK_OUT
);
  timeunit 1ns;
  timeprecision 1ps;
  // Period set by HALF_NS; holds its level while stopped
  initial begin
    REF_CLK_OUT = 1'b0;
    forever begin
      #HALF_NS;
      if (!STOP_IN) REF_CLK_OUT = ~REF_CLK_OUT;
    end
  end
endmodule
`default_nettype wire

// ===== sim/dcg_clock_gen_monitor.sv
`default_nettype none
module dcg_mon #(parameter longint LOCK_CYCLES = 20) (
  // Clock and reset
  input wire logic REF_CLK_IN,
  input wire logic RST_N_IN,
  // Bus
  input wire logic HSEL_IN,
  input wire logic HWRITE_IN,
  input wire logic HREADY_IN,
  input wire logic HREADYOUT_OUT,
  input wire logic HRESP_OUT,
  input wire logic [1:0] HTRANS_IN,
  input wire logic [31:0] HADDR_IN,
  input wire logic [31:0] HWDATA_IN,
  input wire logic [31:0] HRDATA_OUT,
  // Clock outputs
  input wire logic MACHINE_CLK_EN_OUT,
  input wire logic MACHINE_CLOCK_OUTPUT_OUT,
  input wire logic CRYSTAL_OSC_EN_OUT,
  input wire logic PLL_LOCKED_OUT
);
  longint low_d, low_q;
  default clocking @(posedge REF_CLK_IN); endclocking
  default disable iff (!RST_N_IN);
  // Cycles spent unlocked
  always_comb low_d = PLL_LOCKED_OUT ? 0 : low_q + 1;
  always_ff @(posedge REF_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      low_q <= '0;
    end else begin
      low_q <= low_d;
    end
  end
  sequence take_s(w, a);
    HSEL_IN && HREADY_IN && HTRANS_IN[1] && HWRITE_IN == w && HADDR_IN[7:0] == a;
  endsequence
  AST_READY: assert property (HREADYOUT_OUT) else $error("wait state");
  AST_RESP: assert property (!HRESP_OUT) else $error("error response");
  AST_OSC: assert property ($past(RST_N_IN, 3) |-> $stable(CRYSTAL_OSC_EN_OUT)) else $error("osc moved");
  AST_LOCK: assert property ($rose(PLL_LOCKED_OUT) |-> low_q >= LOCK_CYCLES) else $error("early lock");
  AST_RELOCK: assert property (take_s(1'b1, 8'h00) ##1 HWDATA_IN[1] |-> ##[0:2] !PLL_LOCKED_OUT)
    else $error("no relock");
  AST_OUT_CLK_STEP: assert property ($changed(MACHINE_CLOCK_OUTPUT_OUT)
    |-> MACHINE_CLK_EN_OUT || $past(MACHINE_CLK_EN_OUT)) else $error("machine_clock_output step");
  AST_HOLE: assert property (take_s(1'b0, 8'h0c) |=> HRDATA_OUT == 32'h0) else $error("unmapped read");
  AST_STATUS: assert property (take_s(1'b0, 8'h08) |=> HRDATA_OUT[1] == CRYSTAL_OSC_EN_OUT)
    else $error("osc status");
endmodule
bind dcg_clock_gen dcg_mon #(.LOCK_CYCLES(LOCK_CYCLES)) u_mon (.*);
`default_nettype wire

// ===== sim/dcg_clock_gen_test.sv
`default_nettype none
module dcg_clock_gen_test;
  timeunit 1ns;
  timeprecision 1ps;
  localparam longint LCK = 20;
  logic clk, rst_n, stop, hsel, hw, en, co, osc, lk, rdy, rsp;
  logic [1:0] ht, frac;
  logic [2:0] pins;
  logic [3:0] mult;
  logic [31:0] ha, wd, hr, rd;
  int fail_count, check_count, ne, nt, n;
  dcg_ref_src u_src (.STOP_IN(stop), .REF_CLK_OUT(clk));
  dcg_clock_gen #(.LOCK_CYCLES(LCK)) i_dut (.REF_CLK_IN(clk), .RST_N_IN(rst_n), .CLOCK_MODE_PIN_A_IN(pins[2]),
    .CLOCK_MODE_PIN_B_IN(pins[1]), .CLOCK_MODE_PIN_C_IN(pins[0]), .HSEL_IN(hsel), .HADDR_IN(ha), .HTRANS_IN(ht),
    .HWRITE_IN(hw), .HSIZE_IN(3'h2), .HWDATA_IN(wd), .HREADY_IN(rdy), .HRDATA_OUT(hr), .HREADYOUT_OUT(rdy),
    .HRESP_OUT(rsp), .MACHINE_CLK_EN_OUT(en), .MACHINE_CLOCK_OUTPUT_OUT(co), .CRYSTAL_OSC_EN_OUT(osc),
    .PLL_LOCKED_OUT(lk), .PLL_MULT_OUT(mult), .PLL_FRAC_OUT(frac));
  task close_out;
    if (fail_count == 0 && check_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task chk(input string s, input logic [31:0] seen, exp);
    check_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %s exp %h seen %h", s, exp, seen);
    end
  endtask
  // Waits for bus ready, or for lock when c is set
  task tick(input logic c);
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (c ? lk !== 1'b1 && n < 99 : rdy !== 1'b1 && n < 9);
    if (n >= (c ? 99 : 9)) begin
      fail_count++;
      close_out;
    end
  endtask
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    {hsel, hw, ht, ha} <= {1'b1, w, dcg_pkg::HTRANS_NONSEQ, 24'h0, a};
    tick(1'b0);
    {hsel, ht, wd} <= {1'b0, 2'h0, d};
    tick(1'b0);
    rd = hr;
  endtask
  task rst(input logic [2:0] p);
    {rst_n, pins} <= {1'b0, p};
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
  endtask
  // Machine pulses and clock output toggles over 40 cycles
  task cnt;
    logic last;
    logic pe;
    ne = 0;
    nt = 0;
    last = co;
    pe = en;
    repeat (40) begin
      @(posedge clk);
      ne += pe;
      nt += co ^ last;
      last = co;
      pe = en;
    end
  endtask
  task t_pins;
    logic [2:0] pat [3];
    pat = '{3'h0, 3'h5, 3'h7};
    for (int i = 0; i < 3; i++) begin
      rst(pat[i]);
      pins <= ~pat[i];
      cnt;
      chk("pulses", ne, pat[i] == dcg_pkg::PINS_DIV4 ? 10 : 20);
      chk("toggles", nt, ne / 4);
      chk("osc", osc, pat[i] == dcg_pkg::PINS_OSC_DIV2);
      bus(1'b0, dcg_pkg::STATUS_ADDR, 32'h0);
      chk("pins", rd[6:4], pat[i]);
    end
    bus(1'b0, dcg_pkg::BANK_SW_ADDR, 32'h0);
    chk("out_sel", rd[1:0], dcg_pkg::OUT_DIV_RESET);
    bus(1'b1, dcg_pkg::BANK_SW_ADDR, {30'h0, dcg_pkg::OUT_DIV_BY2});
    bus(1'b0, dcg_pkg::BANK_SW_ADDR, 32'h0);
    chk("by2_sel", rd[1:0], dcg_pkg::OUT_DIV_BY2);
    cnt;
    chk("by2", nt, ne / 2);
    bus(1'b1, dcg_pkg::BANK_SW_ADDR, {30'h0, dcg_pkg::OUT_DIV_NONE});
    bus(1'b0, 8'h0c, 32'h0);
    chk("unmapped", rd, 32'h0);
    cnt;
    chk("undivided", nt, ne);
  endtask
  task t_pll;
    rst(3'h2);
    for (int i = 1; i < 4; i++) begin
      bus(1'b1, dcg_pkg::CLK_MODE_ADDR, {24'h0, 4'(i * 5), 2'(i), 2'h2});
      tick(1'b1);
      chk("wait", n >= LCK, 1'b1);
      chk("mode", {lk, mult, frac}, {1'b1, 4'(i * 5), 2'(i)});
    end
    stop = 1'b1;
    #2000;
    stop = 1'b0;
    @(posedge clk);
    chk("static", {lk, mult, frac}, 7'h7f);
    bus(1'b1, dcg_pkg::CLK_MODE_ADDR, 32'h2);
    repeat (2) @(posedge clk);
    chk("mult0", mult, dcg_pkg::MULT_RESET);
  endtask
  initial begin
    {stop, rst_n, hsel, hw, ht, pins, ha, wd} = '0;
    fail_count = 0;
    check_count = 0;
    t_pins;
    t_pll;
    close_out;
  end
endmodule
`default_nettype wire
